//--- src/dlt_defs.vh
`ifndef DLT_DEFS_VH
`define DLT_DEFS_VH
// query parameter layout
`define DLT_LEN_BYTES    8'h2C
`define DLT_PARAM_ID     8'h9A
`define DLT_PARAM_LEN    8'h2A
`define DLT_ROW_COUNT    8'h05
`define DLT_ROW_BYTES    8'h08
`define DLT_HDR_F        8'h46
`define DLT_HDR_C        8'h43
// ddr read opcodes
`define DLT_OP_FAST3     8'h0D
`define DLT_OP_FAST4     8'h0E
`define DLT_OP_DUAL3     8'hBD
`define DLT_OP_DUAL4     8'hBE
`define DLT_OP_QUAD3     8'hED
`define DLT_OP_QUAD4     8'hEE
// mode cycles, same for every code
`define DLT_MODE_FAST    8'h04
`define DLT_MODE_DUAL    8'h02
`define DLT_MODE_QUAD    8'h01
// latency cycles per code and read kind
`define DLT_LAT_11_FAST  8'h01
`define DLT_LAT_11_DUAL  8'h02
`define DLT_LAT_11_QUAD  8'h03
`define DLT_LAT_00_FAST  8'h02
`define DLT_LAT_00_DUAL  8'h04
`define DLT_LAT_00_QUAD  8'h06
`define DLT_LAT_01_FAST  8'h04
`define DLT_LAT_01_DUAL  8'h05
`define DLT_LAT_01_QUAD  8'h07
`define DLT_LAT_10_FAST  8'h05
`define DLT_LAT_10_DUAL  8'h06
`define DLT_LAT_10_QUAD  8'h08
// frequency limits in MHz
`define DLT_FREQ_50      8'h32
`define DLT_FREQ_66      8'h42
// latency codes
`define DLT_CODE_11      2'h3
`define DLT_CODE_00      2'h0
`define DLT_CODE_01      2'h1
`define DLT_CODE_10      2'h2
// read kinds
`define DLT_KIND_FAST    2'h0
`define DLT_KIND_DUAL    2'h1
`define DLT_KIND_QUAD    2'h2
`endif

//--- src/dlt_rom.v
`timescale 1ns/1ps
`include "dlt_defs.vh"
// table contents with registered read data
module dlt_rom (
    input  wire       clk_i,
    input  wire       rst_i,
    input  wire [5:0] addr_i,
    output reg  [7:0] data_o
);
    reg [7:0] next_data;

    // unmapped offsets read as ff, like erased query space
    always @* begin
        case (addr_i)
            6'h00: next_data = `DLT_PARAM_ID;
            6'h01: next_data = `DLT_PARAM_LEN;
            6'h02: next_data = `DLT_ROW_COUNT;
            6'h03: next_data = `DLT_ROW_BYTES;
            6'h04: next_data = `DLT_HDR_F;
            6'h05: next_data = `DLT_HDR_C;
            6'h06: next_data = `DLT_OP_FAST3;
            6'h07: next_data = `DLT_OP_FAST4;
            6'h08: next_data = `DLT_OP_DUAL3;
            6'h09: next_data = `DLT_OP_DUAL4;
            6'h0A: next_data = `DLT_OP_QUAD3;
            6'h0B: next_data = `DLT_OP_QUAD4;
            6'h0C: next_data = `DLT_FREQ_50;
            6'h0D: next_data = {6'h00, `DLT_CODE_11};
            6'h0E: next_data = `DLT_MODE_FAST;
            6'h0F: next_data = `DLT_LAT_11_FAST;
            6'h10: next_data = `DLT_MODE_DUAL;
            6'h11: next_data = `DLT_LAT_11_DUAL;
            6'h12: next_data = `DLT_MODE_QUAD;
            6'h13: next_data = `DLT_LAT_11_QUAD;
            6'h14: next_data = `DLT_FREQ_66;
            6'h15: next_data = {6'h00, `DLT_CODE_00};
            6'h16: next_data = `DLT_MODE_FAST;
            6'h17: next_data = `DLT_LAT_00_FAST;
            6'h18: next_data = `DLT_MODE_DUAL;
            6'h19: next_data = `DLT_LAT_00_DUAL;
            6'h1A: next_data = `DLT_MODE_QUAD;
            6'h1B: next_data = `DLT_LAT_00_QUAD;
            6'h1C: next_data = `DLT_FREQ_66;
            6'h1D: next_data = {6'h00, `DLT_CODE_01};
            6'h1E: next_data = `DLT_MODE_FAST;
            6'h1F: next_data = `DLT_LAT_01_FAST;
            6'h20: next_data = `DLT_MODE_DUAL;
            6'h21: next_data = `DLT_LAT_01_DUAL;
            6'h22: next_data = `DLT_MODE_QUAD;
            6'h23: next_data = `DLT_LAT_01_QUAD;
            6'h24: next_data = `DLT_FREQ_66;
            6'h25: next_data = {6'h00, `DLT_CODE_10};
            6'h26: next_data = `DLT_MODE_FAST;
            6'h27: next_data = `DLT_LAT_10_FAST;
            6'h28: next_data = `DLT_MODE_DUAL;
            6'h29: next_data = `DLT_LAT_10_DUAL;
            6'h2A: next_data = `DLT_MODE_QUAD;
            6'h2B: next_data = `DLT_LAT_10_QUAD;
            default: next_data = 8'hFF;
        endcase
    end

    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            data_o <= 8'h00;
        end else begin
            data_o <= next_data;
        end
    end
endmodule

//--- src/dlt_top.v
`timescale 1ns/1ps
`include "dlt_defs.vh"
// Notes on behaviour
// - offset 0 reads 9Ah, the ddr latency table identifier.
// - offset 1 reads 2Ah bytes following; next parameter at here plus that plus one.
// - five rows of eight bytes; header starts with ascii F and C.
// - header first command column: fast ddr read opcodes 0Dh then 0Eh.
// - header second command column: ddr dual i/o opcodes BDh then BEh.
// - header third command column: ddr quad i/o opcodes EDh then EEh.
// - mode cycles are four fast, two dual, one quad for every code.
// - code 11b up to 50 MHz, latency 1/2/3.
// - code 00b up to 66 MHz, latency 2/4/6.
// - code 01b up to 66 MHz, latency 4/5/7.
// - code 10b up to 66 MHz, latency 5/6/8.
//
// query port: the host shifts an offset byte in msb first on sck rising edges
// while cs_n is low, then reads table bytes msb first; data changes on falling
// sck edges and the offset auto-increments. a second path reports the wait
// for a ddr read given kind and configured latency code.
module dlt_top (
    input  wire       clk_i,
    input  wire       rst_i,
    input  wire       sck_i,
    input  wire       cs_n_i,
    input  wire       mosi_i,
    output reg        miso_o,
    output reg        miso_oe_o,
    input  wire [1:0] lat_code_i,
    input  wire [1:0] read_kind_i,
    input  wire       read_start_i,
    output reg        data_phase_o,
    output reg        wait_busy_o
);
    // two-flop synchronisers for the link pins
    reg  [1:0] sck_sync;
    reg  [1:0] cs_sync;
    reg  [1:0] mosi_sync;
    reg        sck_prev;
    wire       sck_rise;
    wire       sck_fall;
    wire       cs_act;

    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sck_sync  <= 2'h0;
            cs_sync   <= 2'h3;
            mosi_sync <= 2'h0;
            sck_prev  <= 1'b0;
        end else begin
            sck_sync  <= {sck_sync[0], sck_i};
            cs_sync   <= {cs_sync[0], cs_n_i};
            mosi_sync <= {mosi_sync[0], mosi_i};
            sck_prev  <= sck_sync[1];
        end
    end

    assign sck_rise = sck_sync[1] & ~sck_prev;
    assign sck_fall = ~sck_sync[1] & sck_prev;
    assign cs_act   = ~cs_sync[1];

    // query shift engine
    reg  [2:0] bit_cnt;
    reg        addr_done;
    reg  [7:0] shift_in;
    reg  [5:0] rd_addr;
    reg  [7:0] shift_out;
    reg  [1:0] load_pend;
    wire [7:0] rom_data;

    dlt_rom u_rom (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .addr_i (rd_addr),
        .data_o (rom_data)
    );

    // rom read is registered, so the byte is valid two clocks after the
    // address update: one for the address register, one for the rom output.
    // loading after one clock would pick up the previous offset's byte.
    // sck at 200 ns period leaves several clocks of margin before the next fall
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            bit_cnt   <= 3'h0;
            addr_done <= 1'b0;
            shift_in  <= 8'h00;
            rd_addr   <= 6'h00;
            shift_out <= 8'hFF;
            load_pend <= 2'h0;
            miso_o    <= 1'b0;
            miso_oe_o <= 1'b0;
        end else if (!cs_act) begin
            bit_cnt   <= 3'h0;
            addr_done <= 1'b0;
            load_pend <= 2'h0;
            miso_oe_o <= 1'b0;
            miso_o    <= 1'b0;
        end else begin
            // two-stage load delay; a fresh address request below overrides it
            load_pend <= {load_pend[0], 1'b0};
            if (load_pend[1]) begin
                shift_out <= rom_data;
            end
            if (!addr_done && sck_rise) begin
                shift_in <= {shift_in[6:0], mosi_sync[1]};
                bit_cnt  <= bit_cnt + 3'h1;
                if (bit_cnt == 3'h7) begin
                    addr_done <= 1'b1;
                    // offsets are cut to 6 bits; those that land past the table read ff
                    rd_addr   <= {shift_in[4:0], mosi_sync[1]};
                    load_pend <= 2'h1;
                end
            end else if (addr_done && sck_fall) begin
                miso_oe_o <= 1'b1;
                miso_o    <= shift_out[7];
                shift_out <= {shift_out[6:0], 1'b1};
                bit_cnt   <= bit_cnt + 3'h1;
                if (bit_cnt == 3'h7) begin
                    rd_addr   <= rd_addr + 6'h01;
                    load_pend <= 2'h1;
                end
            end
        end
    end

    // mode plus latency wait per kind and code
    function [7:0] dlt_wait;
        input [1:0] kind;
        input [1:0] code;
        reg   [1:0] knd;
        reg   [7:0] mode;
        reg   [7:0] lat;
        begin
            // kind 3 has no column of its own, so it borrows both quad entries
            knd  = (kind == 2'h3) ? `DLT_KIND_QUAD : kind;
            mode = (knd == `DLT_KIND_FAST) ? `DLT_MODE_FAST :
                   (knd == `DLT_KIND_DUAL) ? `DLT_MODE_DUAL : `DLT_MODE_QUAD;
            case ({knd, code})
                {`DLT_KIND_FAST, `DLT_CODE_11}: lat = `DLT_LAT_11_FAST;
                {`DLT_KIND_DUAL, `DLT_CODE_11}: lat = `DLT_LAT_11_DUAL;
                {`DLT_KIND_QUAD, `DLT_CODE_11}: lat = `DLT_LAT_11_QUAD;
                {`DLT_KIND_FAST, `DLT_CODE_00}: lat = `DLT_LAT_00_FAST;
                {`DLT_KIND_DUAL, `DLT_CODE_00}: lat = `DLT_LAT_00_DUAL;
                {`DLT_KIND_QUAD, `DLT_CODE_00}: lat = `DLT_LAT_00_QUAD;
                {`DLT_KIND_FAST, `DLT_CODE_01}: lat = `DLT_LAT_01_FAST;
                {`DLT_KIND_DUAL, `DLT_CODE_01}: lat = `DLT_LAT_01_DUAL;
                {`DLT_KIND_QUAD, `DLT_CODE_01}: lat = `DLT_LAT_01_QUAD;
                {`DLT_KIND_FAST, `DLT_CODE_10}: lat = `DLT_LAT_10_FAST;
                {`DLT_KIND_DUAL, `DLT_CODE_10}: lat = `DLT_LAT_10_DUAL;
                {`DLT_KIND_QUAD, `DLT_CODE_10}: lat = `DLT_LAT_10_QUAD;
                // unreachable once kind 3 is folded; longest wait is the safe choice
                default: lat = `DLT_LAT_10_QUAD;
            endcase
            dlt_wait = mode + lat;
        end
    endfunction

    // wait counter runs on sck rising edges; kind 3 is treated as quad
    reg [7:0] wait_cnt;

    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wait_cnt     <= 8'h00;
            wait_busy_o  <= 1'b0;
            data_phase_o <= 1'b0;
        end else if (!cs_act) begin
            wait_cnt     <= 8'h00;
            wait_busy_o  <= 1'b0;
            data_phase_o <= 1'b0;
        end else if (read_start_i && !wait_busy_o && !data_phase_o) begin
            wait_cnt    <= dlt_wait(read_kind_i, lat_code_i);
            wait_busy_o <= 1'b1;
        end else if (wait_busy_o && sck_rise) begin
            wait_cnt <= wait_cnt - 8'h01;
            if (wait_cnt == 8'h01) begin
                wait_busy_o  <= 1'b0;
                data_phase_o <= 1'b1;
            end
        end
    end
endmodule

//--- sim/dlt_chk_sva.sv
`timescale 1ns/1ps
// port checks of the query and wait paths
module dlt_chk (
    input logic clk_i,
    input logic rst_i,
    input logic sck_i,
    input logic cs_n_i,
    input logic read_start_i,
    input logic miso_o,
    input logic miso_oe_o,
    input logic data_phase_o,
    input logic wait_busy_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // start counts only once the synchronised select is low
    property p_start; (!cs_n_i)[*4] ##0 (read_start_i && !wait_busy_o && !data_phase_o) |=> wait_busy_o; endproperty
    a_start: assert property (p_start) else $error("wait not started");
    property p_excl; !(wait_busy_o && data_phase_o); endproperty
    a_excl: assert property (p_excl) else $error("busy during data phase");
    property p_rise; $rose(data_phase_o) |-> $fell(wait_busy_o); endproperty
    a_rise: assert property (p_rise) else $error("data phase without wait end");
    // no sck rise seen, so the wait cannot run out
    property p_busy_hold; (wait_busy_o && !cs_n_i && !sck_i)[*3] |=> wait_busy_o; endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("wait ended without sck");
    property p_dp_keep; data_phase_o && !cs_n_i |=> data_phase_o; endproperty
    a_dp_keep: assert property (p_dp_keep) else $error("data phase dropped");
    property p_dp_clr; cs_n_i[*6] |-> !data_phase_o; endproperty
    a_dp_clr: assert property (p_dp_clr) else $error("data phase after deselect");
    property p_oe_clr; cs_n_i[*6] |-> !miso_oe_o; endproperty
    a_oe_clr: assert property (p_oe_clr) else $error("miso driven while deselected");
    // data only moves on falling sck
    property p_miso_hold; (sck_i && !cs_n_i)[*4] |-> $stable(miso_o); endproperty
    a_miso_hold: assert property (p_miso_hold) else $error("miso moved with sck high");
endmodule
bind dlt_top dlt_chk chk_u (.clk_i(clk_i), .rst_i(rst_i), .sck_i(sck_i), .cs_n_i(cs_n_i),
    .read_start_i(read_start_i), .miso_o(miso_o), .miso_oe_o(miso_oe_o),
    .data_phase_o(data_phase_o), .wait_busy_o(wait_busy_o));

//--- sim/dlt_host.sv
`timescale 1ns/1ps
// query host; sck runs only inside frames
module dlt_host (
    input  wire clk_i,
    input  wire miso_i,
    output reg  sck_o,
    output reg  cs_n_o,
    output reg  mosi_o
);
    initial begin
        sck_o = 1'b0;
        cs_n_o = 1'b1;
        mosi_o = 1'b1;
    end
    task half;
        repeat (4) @(negedge clk_i);
    endtask
    // 5 MHz sck, well below every row's limit
    task tick(input bit b, output bit s);
        sck_o = 1'b0;
        mosi_o = b;
        half;
        s = miso_i;
        sck_o = 1'b1;
        half;
    endtask
    task sel;
        cs_n_o = 1'b0;
        half;
    endtask
    task start(input logic [7:0] off);
        bit s;
        sel;
        for (int i = 7; i >= 0; i--)
            tick(off[i], s);
    endtask
    // mosi toggles so a stale line never looks valid
    task get(output logic [7:0] v);
        for (int i = 7; i >= 0; i--)
            tick(~mosi_o, v[i]);
    endtask
    task stop;
        sck_o = 1'b0;
        half;
        cs_n_o = 1'b1;
        half;
        half;
    endtask
endmodule

//--- sim/tb.sv
`timescale 1ns/1ps
module tb;
    logic       clk_i = 1'b0;
    logic       rst_i = 1'b1;
    logic [1:0] lat_code_i = 2'h0;
    logic [1:0] read_kind_i = 2'h0;
    logic       read_start_i = 1'b0;
    wire        sck_i, cs_n_i, mosi_i, miso_o, miso_oe_o, data_phase_o, wait_busy_o;
    int         err_total = 0;
    int         n_compared = 0;
    int         cyc = 0;
    logic [31:0] rng = 32'hC6A86BCF;
    logic [7:0] tbl [64];
    logic [7:0] hd [12] = '{8'h9A, 8'h2A, 8'h05, 8'h08, 8'h46, 8'h43, 8'h0D, 8'h0E, 8'hBD, 8'hBE, 8'hED, 8'hEE};
    logic [7:0] fq [4] = '{8'h32, 8'h42, 8'h42, 8'h42};
    logic [1:0] cd [4] = '{2'h3, 2'h0, 2'h1, 2'h2};
    logic [7:0] md [3] = '{8'h04, 8'h02, 8'h01};
    logic [7:0] lt [4][3] = '{'{8'h01, 8'h02, 8'h03}, '{8'h02, 8'h04, 8'h06}, '{8'h04, 8'h05, 8'h07}, '{8'h05, 8'h06, 8'h08}};
    always #12.5 clk_i = ~clk_i;
    dlt_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .sck_i(sck_i), .cs_n_i(cs_n_i), .mosi_i(mosi_i),
        .miso_o(miso_o), .miso_oe_o(miso_oe_o), .lat_code_i(lat_code_i), .read_kind_i(read_kind_i),
        .read_start_i(read_start_i), .data_phase_o(data_phase_o), .wait_busy_o(wait_busy_o));
    dlt_host host_u (.clk_i(clk_i), .miso_i(miso_o), .sck_o(sck_i), .cs_n_o(cs_n_i), .mosi_o(mosi_i));
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        x = x ^ (x << 5);
        return x;
    endfunction
    task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    task tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // hang guard, about 2.7 times the expected run of some 7500 clocks
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            tally_and_finish;
        end
    end
    initial begin
        logic [7:0] v;
        logic [7:0] o;
        int n;
        int k;
        // expected image, FFh beyond the parameter
        foreach (tbl[i])
            tbl[i] = (i < 12) ? hd[i] : 8'hFF;
        for (int r = 0; r < 4; r++) begin
            tbl[12 + 8 * r] = fq[r];
            tbl[13 + 8 * r] = {6'h00, cd[r]};
            for (int j = 0; j < 3; j++) begin
                tbl[14 + 8 * r + 2 * j] = md[j];
                tbl[15 + 8 * r + 2 * j] = lt[r][j];
            end
        end
        repeat (5) @(negedge clk_i);
        rst_i = 1'b0;
        repeat (3) @(negedge clk_i);
        host_u.start(8'h00);
        for (int i = 0; i < 64; i++) begin
            host_u.get(v);
            chk("table byte", tbl[i], v);
            chk("miso enable", 8'h01, {7'h00, miso_oe_o});
        end
        host_u.stop;
        chk("miso enable idle", 8'h00, {7'h00, miso_oe_o});
        // random offsets, bursts of three
        repeat (8) begin
            rng = xs(rng);
            o = rng[7:0];
            host_u.start(o);
            for (int i = 0; i < 3; i++) begin
                host_u.get(v);
                chk("burst byte", tbl[(o + i) % 64], v);
            end
            host_u.stop;
        end
        // every code with every read kind, kind 3 reads as quad
        for (int c = 0; c < 16; c++) begin
            k = (c % 4 == 3) ? 2 : c % 4;
            n = md[k] + lt[c / 4][k];
            lat_code_i = cd[c / 4];
            read_kind_i = 2'(c % 4);
            host_u.sel;
            read_start_i = 1'b1;
            @(negedge clk_i);
            read_start_i = 1'b0;
            @(negedge clk_i);
            chk("wait busy", 8'h01, {7'h00, wait_busy_o});
            for (int j = 1; j <= n; j++) begin
                host_u.tick(1'b0, v[0]);
                chk("data phase", {7'h00, j == n}, {7'h00, data_phase_o});
            end
            host_u.stop;
            chk("data phase idle", 8'h00, {7'h00, data_phase_o});
        end
        tally_and_finish;
    end
endmodule
